// ### src/asf_pkg.sv
// Package for the converter status flag logic: constants and rule summary
// Function
// - End of conversion with data ready already set raises global overrun, even during status read.
// - Status read clears global overrun unless a new overrun arrives that cycle.
// - Channel data read during another channel's overrunning conversion still raises global overrun.
// - Another channel's disable during end of conversion on a flagged channel sets channel overrun, and global overrun when data ready is set.
// - Channel data read or last result read clears that channel's end flag.
// - Status read clears channel overrun even while that channel's cleared end flag is set again, but not if that flag was still set.
// - A channel disabled mid-conversion gets no end flag for it unless it is re-enabled while still running.
// - Channel data read clears only the addressed channel's end flag.
// - Sleep enabled while idle takes effect only after the next conversion ends.
// - Data ready clears only on a last result read.
package asf_pkg;

  localparam int unsigned ASF_NUM_CH      = 8;
  localparam int unsigned ASF_DATA_W      = 10;
  localparam logic        ASF_FLAG_RST    = 1'b0;
  localparam logic        ASF_SLEEP_RST   = 1'b0;

endpackage

// ### src/asf_status_flags.sv
// Status flag logic of the converter controller
`timescale 1ns/1ns

module asf_status_flags
  import asf_pkg::*;
#(
  parameter int unsigned NUM_CH = ASF_NUM_CH,
  parameter int unsigned DATA_W = ASF_DATA_W,
  parameter int unsigned CH_W   = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Conversion core
  input  wire logic              eoc_i,
  input  wire logic [CH_W-1:0]   eoc_ch_i,
  input  wire logic [DATA_W-1:0] eoc_data_i,
  input  wire logic [NUM_CH-1:0] conv_running_i,
  // Software accesses
  input  wire logic              status_rd_i,
  input  wire logic              chan_rd_i,
  input  wire logic [CH_W-1:0]   chan_rd_ch_i,
  input  wire logic              last_rd_i,
  input  wire logic [NUM_CH-1:0] chan_en_i,
  input  wire logic              sleep_en_i,
  // Status
  output logic [NUM_CH-1:0]      eoc_flags_o,
  output logic [NUM_CH-1:0]      channel_overrun_flag_o,
  output logic                   data_ready_flag_o,
  output logic                   global_overrun_flag_o,
  output logic [DATA_W-1:0]      last_result_reg_o,
  output logic [DATA_W-1:0]      channel_result_reg_o,
  output logic                   sleep_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_CH-1:0] eoc;
    logic [NUM_CH-1:0] ovr;
    logic              dready;
    logic              govr;
    logic              sleep_armed;
    logic              sleep;
    logic [NUM_CH-1:0] dis_mid;
    logic [DATA_W-1:0] last;
    logic [DATA_W-1:0] rd_data;
    logic [CH_W-1:0]   last_ch;
  } asf_state_s;

  asf_state_s state_reg;
  asf_state_s state_next;

  logic [DATA_W-1:0] ch_data_reg [NUM_CH];

  function automatic logic [NUM_CH-1:0] asf_onehot(input logic [CH_W-1:0] ch);
    asf_onehot = '0;
    asf_onehot[ch] = 1'b1;
  endfunction

  logic [NUM_CH-1:0] eoc_vec;
  logic [NUM_CH-1:0] eoc_store;
  logic              store_any;

  // Stores only when the finishing channel is enabled and was not killed mid-run
  always_comb begin
    eoc_vec   = eoc_i ? asf_onehot(eoc_ch_i) : '0;
    eoc_store = eoc_vec & chan_en_i & ~state_reg.dis_mid;
    store_any = |eoc_store;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    // Disabling while running marks the channel until it runs again while enabled
    state_next.dis_mid = (state_reg.dis_mid | (conv_running_i & ~chan_en_i)) & ~(conv_running_i & chan_en_i);
    // Clears first, sets afterwards so the set wins
    if (chan_rd_i) begin
      state_next.eoc = state_next.eoc & ~asf_onehot(chan_rd_ch_i);
    end
    if (last_rd_i) begin
      // The end flag of the channel held in the last-result register goes with the read
      state_next.eoc    = state_next.eoc & ~asf_onehot(state_reg.last_ch);
      state_next.dready = 1'b0;
    end
    if (status_rd_i) begin
      state_next.ovr  = '0;
      state_next.govr = 1'b0;
    end
    // Overruns are judged on the flags as they stood before this cycle
    state_next.ovr = state_next.ovr | (eoc_store & state_reg.eoc);
    if (store_any && state_reg.dready) begin
      state_next.govr = 1'b1;
    end
    state_next.eoc = state_next.eoc | eoc_store;
    if (store_any) begin
      state_next.dready  = 1'b1;
      state_next.last    = eoc_data_i;
      state_next.last_ch = eoc_ch_i;
    end
    if (chan_rd_i) begin
      state_next.rd_data = ch_data_reg[chan_rd_ch_i];
    end
    // Sleep is only entered at a conversion boundary, never straight from idle
    if (!sleep_en_i) begin
      state_next.sleep_armed = 1'b0;
      state_next.sleep       = 1'b0;
    end else begin
      state_next.sleep_armed = 1'b1;
      if (eoc_i && state_reg.sleep_armed) begin
        state_next.sleep = 1'b1;
      end else if (|conv_running_i) begin
        state_next.sleep = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Data store has no reset: contents are only meaningful once its flag is set
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (eoc_store[i]) begin
        ch_data_reg[i] <= eoc_data_i;
      end
    end
  end

  assign eoc_flags_o            = state_reg.eoc;
  assign channel_overrun_flag_o = state_reg.ovr;
  assign data_ready_flag_o      = state_reg.dready;
  assign global_overrun_flag_o  = state_reg.govr;
  assign last_result_reg_o      = state_reg.last;
  assign channel_result_reg_o   = state_reg.rd_data;
  assign sleep_o                = state_reg.sleep;

  // ==========================================================
  // Assertions
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_overrun_event;
    store_any && state_reg.dready;
  endsequence

  sequence s_sleep_option;
    sleep_en_i;
  endsequence

  sequence s_sleep_conv_end;
    sleep_en_i && eoc_i;
  endsequence

  // ==========================================================
  // Global overrun
  a_govr_on_overrun: assert property (s_overrun_event |=> global_overrun_flag_o)
    else $error("global overrun not set after overrun");
  a_govr_status_new: assert property (status_rd_i ##0 s_overrun_event |=> global_overrun_flag_o)
    else $error("global overrun lost to a coinciding status read");
  a_govr_read_clear: assert property (status_rd_i && !(store_any && state_reg.dready)
                                      |=> !global_overrun_flag_o)
    else $error("global overrun not cleared by status read");
  a_govr_chan_read: assert property (chan_rd_i && store_any && data_ready_flag_o |=> global_overrun_flag_o)
    else $error("global overrun lost during channel read");
  a_govr_on_disable: assert property (|(eoc_store & eoc_flags_o) && data_ready_flag_o && !(&chan_en_i)
                                      |=> global_overrun_flag_o)
    else $error("global overrun not set while a channel was disabled");

  // ==========================================================
  // Channel overrun and end flags
  // Every flagged channel that stores again must show its own overrun, not just any overrun
  a_ovr_flagged_eoc: assert property (|(eoc_store & eoc_flags_o)
                                      |=> (channel_overrun_flag_o & $past(eoc_store & eoc_flags_o))
                                          == $past(eoc_store & eoc_flags_o))
    else $error("channel overrun not set");
  a_eoc_read_clear: assert property (chan_rd_i && !eoc_store[chan_rd_ch_i]
                                     |=> !eoc_flags_o[$past(chan_rd_ch_i)])
    else $error("end flag not cleared by channel read");
  a_eoc_clear_last: assert property (last_rd_i && !eoc_store[state_reg.last_ch]
                                     |=> !eoc_flags_o[$past(state_reg.last_ch)])
    else $error("end flag not cleared by last result read");
  a_ovr_status_clear: assert property (status_rd_i && !(|(eoc_store & eoc_flags_o))
                                       |=> channel_overrun_flag_o == '0)
    else $error("channel overrun not cleared by status read");
  a_no_eoc_disabled: assert property (eoc_i && !chan_en_i[eoc_ch_i] && !eoc_flags_o[eoc_ch_i]
                                      |=> !eoc_flags_o[$past(eoc_ch_i)])
    else $error("end flag raised on disabled channel");
  a_no_eoc_killed: assert property (eoc_i && state_reg.dis_mid[eoc_ch_i] && !eoc_flags_o[eoc_ch_i]
                                    |=> !eoc_flags_o[$past(eoc_ch_i)])
    else $error("end flag raised on channel disabled mid conversion");
  a_clear_only_target: assert property (chan_rd_i && !last_rd_i
                                        |=> (($past(eoc_flags_o) & ~eoc_flags_o)
                                             & ~asf_onehot($past(chan_rd_ch_i))) == '0)
    else $error("channel read cleared wrong end flag");
  a_eoc_set_store: assert property (eoc_i && chan_en_i[eoc_ch_i] && !state_reg.dis_mid[eoc_ch_i]
                                    |=> eoc_flags_o[$past(eoc_ch_i)])
    else $error("end flag set lost to a coinciding clear");

  // ==========================================================
  // Data ready and results
  a_ready_hold_chan: assert property (chan_rd_i && !last_rd_i && data_ready_flag_o |=> data_ready_flag_o)
    else $error("data ready cleared by channel read");
  a_ready_clear_last: assert property (last_rd_i && !store_any |=> !data_ready_flag_o)
    else $error("data ready not cleared by last result read");
  a_set_beats_clear: assert property (last_rd_i && store_any |=> data_ready_flag_o)
    else $error("data ready set lost to clear");
  a_last_result_load: assert property (store_any
                                       |=> last_result_reg_o == $past(eoc_data_i))
    else $error("stored result missing from last result");

  // ==========================================================
  // Sleep
  // The option must stand a cycle before the conversion end, so a late option waits one more conversion
  a_sleep_after_conv: assert property (sleep_en_i && !sleep_o && !eoc_i |=> !sleep_o)
    else $error("sleep entered without a conversion end");
  a_sleep_on_end: assert property (s_sleep_option ##1 s_sleep_conv_end |=> sleep_o)
    else $error("sleep not entered after conversion end");
  a_sleep_off_disabled: assert property (!sleep_en_i |=> !sleep_o)
    else $error("sleep kept without the sleep option");

endmodule // asf_status_flags

// ### verif/asf_status_flags_tb.sv
// Self-checking bench for the converter status flags
`timescale 1ns/1ns
module asf_status_flags_tb;
  import asf_pkg::*;
  // ==========
  // Stimulus and observed outputs
  logic       clk = 0, rst_n = 0, eoc = 0, srd = 0, crd = 0, lrd = 0, slp_en = 0;
  logic [2:0] ech = 0, cch = 0;
  logic [9:0] edat = 0, lres, cres;
  logic [7:0] run = 0, en = 8'hff, eocf, ovrf;
  logic       dready, govr, slp;
  int         fails = 0, checked = 0;
  initial forever #20 clk = ~clk;
  asf_status_flags asf_status_flags_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .eoc_i(eoc), .eoc_ch_i(ech), .eoc_data_i(edat),
    .conv_running_i(run), .status_rd_i(srd), .chan_rd_i(crd), .chan_rd_ch_i(cch), .last_rd_i(lrd),
    .chan_en_i(en), .sleep_en_i(slp_en), .eoc_flags_o(eocf), .channel_overrun_flag_o(ovrf),
    .data_ready_flag_o(dready), .global_overrun_flag_o(govr), .last_result_reg_o(lres),
    .channel_result_reg_o(cres), .sleep_o(slp));
  // ==========
  // One cycle of access; every call sets all pulses, so the next call ends the last one
  task automatic cy(input logic e, input logic [2:0] c, input logic [9:0] d, input logic s, r,
                    input logic [2:0] rc, input logic l);
    eoc = e; ech = c; edat = d; srd = s; crd = r; cch = rc; lrd = l;
    @(negedge clk);
  endtask
  task automatic ckf(input logic [7:0] g, x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t flags got %h exp %h", $time, g, x);
    end
  endtask
  task automatic ckd(input logic [9:0] g, x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t data got %h exp %h", $time, g, x);
    end
  endtask
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #100000;
    fails++;
    close_out;
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    ckf({eocf | ovrf}, 8'h00);
    cy(1, 2, 10'h155, 0, 0, 0, 0);
    ckf(eocf, 8'h04);
    ckd(lres, 10'h155);
    cy(0, 0, 0, 0, 1, 2, 0);
    ckf(eocf, 8'h00);
    ckd(cres, 10'h155);
    ckf({7'h0, dready}, 8'h01);
    cy(1, 3, 10'h2aa, 1, 0, 0, 0);
    ckf({7'h0, govr}, 8'h01);
    cy(0, 0, 0, 0, 0, 0, 1);
    ckf({6'h0, govr, dready}, 8'h02);
    ckf(eocf, 8'h00);
    cy(1, 0, 10'h011, 1, 0, 0, 0);
    ckf({6'h0, govr, dready}, 8'h01);
    cy(1, 3, 10'h033, 0, 0, 0, 0);
    ckf(eocf, 8'h09);
    cy(1, 3, 10'h03c, 0, 0, 0, 0);
    ckf(ovrf, 8'h08);
    cy(0, 0, 0, 0, 1, 3, 0);
    ckd(cres, 10'h03c);
    cy(1, 3, 10'h044, 1, 0, 0, 0);
    ckf(ovrf, 8'h00);
    ckf({eocf[7:1], govr}, 8'h09);
    cy(0, 0, 0, 1, 0, 0, 0);
    cy(1, 3, 10'h055, 0, 1, 0, 0);
    ckf(eocf, 8'h08);
    ckf({govr, ovrf[6:0]}, 8'h88);
    cy(0, 0, 0, 1, 0, 0, 0);
    en = 8'hbf;
    cy(1, 3, 10'h066, 0, 0, 0, 0);
    ckf({govr, ovrf[6:0]}, 8'h88);
    en = 8'hff;
    run = 8'h40;
    cy(0, 0, 0, 0, 0, 0, 0);
    en = 8'hbf;
    cy(0, 0, 0, 0, 0, 0, 0);
    run = 8'h00;
    en = 8'hff;
    cy(1, 6, 10'h077, 0, 1, 3, 0);
    ckf(eocf, 8'h00);
    ckd(lres, 10'h066);
    cy(1, 1, 10'h099, 0, 0, 0, 1);
    ckf({eocf[7:1], dready}, 8'h03);
    cy(0, 0, 0, 0, 0, 0, 1);
    ckf({eocf[7:1], dready}, 8'h00);
    slp_en = 1;
    repeat (3) cy(0, 0, 0, 0, 0, 0, 0);
    ckf({7'h0, slp}, 8'h00);
    cy(1, 4, 10'h0aa, 0, 0, 0, 0);
    cy(0, 0, 0, 0, 0, 0, 0);
    ckf({7'h0, slp}, 8'h01);
    slp_en = 0;
    repeat (2) cy(0, 0, 0, 0, 0, 0, 0);
    ckf({7'h0, slp}, 8'h00);
    close_out;
  end
endmodule // asf_status_flags_tb
